// ---- rtl/hli_loader.sv ----
// Start-up configuration loader: strap decode, baud detection and
// initialization-mode command handling for the host link.
// Assumes a byte-level command parser and a persistent store port on core_clk.
`timescale 1ns/10ps
`default_nettype none

module hli_loader #(
  parameter int SETTLE_CYC = hli_pkg::UART_SETTLE_CYC,
  parameter int MEAS_W = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Clock option straps and receive pin
  input wire logic clock_strap_a,
  input wire logic clock_strap_b,
  input wire logic clock_strap_c,
  input wire logic rx_pin,
  // Persistent store
  input wire hli_pkg::hli_store_s store_info,
  output logic store_wr_valid,
  output hli_pkg::hli_wr_s store_wr,
  input wire logic store_wr_ready,
  // Commands from host link
  input wire logic cmd_valid,
  input wire hli_pkg::hli_cmd_s cmd,
  output logic cmd_ready,
  // Events toward host link
  output logic evt_valid,
  output hli_pkg::hli_evt_s evt,
  input wire logic evt_ready,
  // Resulting configuration
  output logic [15:0] uart_div,
  output logic [23:0] clock_khz,
  output logic [47:0] local_device_address,
  output logic uart_ready,
  output logic init_mode,
  output logic cmd_if_on
);

  // ----------------------------------------------------------------
  // Strap decode and input synchronisers
  // ----------------------------------------------------------------
  typedef enum {S_STRAP, S_DEFAULT, S_DETECT, S_SETTLE, S_ROUTE, S_ANNOUNCE, S_CONFIG,
    S_NORMAL} hli_state_e;

  function automatic hli_pkg::hli_link_mode_e strap_mode(input logic [2:0] s);
    unique case (s)
      3'h5: strap_mode = hli_pkg::LM_FIX_9K6;
      3'h6: strap_mode = hli_pkg::LM_FIX_115K2;
      3'h7: strap_mode = hli_pkg::LM_FIX_921K6;
      3'h2: strap_mode = hli_pkg::LM_DETECT;
      default: strap_mode = hli_pkg::LM_STORE; // Unlisted codes read speed from store
    endcase
  endfunction

  logic [3:0] sync1_r, sync2_r, sync3_r;
  logic [3:0] filt_r;
  hli_state_e state_r;
  hli_pkg::hli_link_mode_e mode_r;
  logic [2:0] scnt_r;
  logic [1:0] meas_ph_r;
  logic [MEAS_W-1:0] meas_r;
  logic [31:0] settle_r;
  logic init_r, addr_got_r, timing_got_r, evt_v_r, wr_v_r, begin_r;
  hli_pkg::hli_evt_s evt_r;
  hli_pkg::hli_wr_s wr_r;
  logic [15:0] div_r, pend_div_r;
  logic [23:0] khz_r, pend_khz_r;
  logic [47:0] addr_r, pend_addr_r;
  logic [7:0] patch_idx_r;

  // Three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    sync1_r <= {rx_pin, clock_strap_a, clock_strap_b, clock_strap_c};
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  wire [3:0] agree = ~(sync2_r ^ sync3_r);
  wire [3:0] filt_nxt = (agree & sync3_r) | (~agree & filt_r);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // Receive bit resets to its idle high level so no false edge follows
      filt_r <= 4'h8;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  wire rx_lvl = filt_r[3];
  wire rx_rise = filt_nxt[3] & ~rx_lvl;
  wire rx_fall = ~filt_nxt[3] & rx_lvl;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  // For initialization, an empty store counts as no store at all
  wire store_ok = store_info.present & ~store_info.empty;
  wire need_init = ~store_ok | ~store_info.complete;
  wire detect_mode = (mode_r == hli_pkg::LM_DETECT);
  wire cmd_take = cmd_valid & cmd_ready;
  // Begin needs an address always, and timing only when detecting
  wire begin_ok = addr_got_r & (~detect_mode | timing_got_r);
  wire store_cmd = (cmd.code == hli_pkg::CMD_SET_TIMING) |
    (cmd.code == hli_pkg::CMD_STORE_LOCAL) | (cmd.code == hli_pkg::CMD_PATCH);
  // Counter ends one short of the interval; eight bits fill the window
  wire [MEAS_W-1:0] meas_bit = (meas_r + MEAS_W'(1)) >> 3;
  wire settle_done = (settle_r >= 32'(SETTLE_CYC - 1));

  // Handshake outputs; commands stall while an answer or a store write is pending
  assign cmd_ready = (state_r == S_CONFIG) & ~evt_v_r & ~wr_v_r & ~begin_r;
  assign evt_valid = evt_v_r;
  assign evt = evt_r;
  assign store_wr_valid = wr_v_r;
  assign store_wr = wr_r;
  assign uart_div = div_r;
  assign clock_khz = khz_r;
  assign local_device_address = addr_r;
  assign init_mode = init_r;
  assign cmd_if_on = (state_r == S_NORMAL);
  assign uart_ready = (state_r != S_STRAP) & (state_r != S_DETECT) &
    (state_r != S_SETTLE) & (state_r != S_DEFAULT);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reset wipes every configured value: nothing survives without a store
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= S_STRAP;
      mode_r <= hli_pkg::LM_STORE;
      scnt_r <= 3'h0;
      meas_ph_r <= 2'h0;
      meas_r <= '0;
      settle_r <= 32'h0;
      init_r <= 1'b0;
      evt_v_r <= 1'b0;
      evt_r <= '0;
      wr_v_r <= 1'b0;
      wr_r <= '0;
      begin_r <= 1'b0;
      div_r <= hli_pkg::DIV_RESET;
    end else begin
      if (evt_v_r && evt_ready) begin
        evt_v_r <= 1'b0;
      end
      if (wr_v_r && store_wr_ready) begin
        wr_v_r <= 1'b0;
      end
      unique case (state_r)
        S_STRAP: begin
          scnt_r <= scnt_r + 3'h1;
          if (scnt_r == 3'(hli_pkg::STRAP_SETTLE_CYC - 1)) begin
            mode_r <= strap_mode(filt_r[2:0]);
            if (store_info.present && store_info.empty) begin
              // First boot: write the default 9600 divider to the store
              wr_v_r <= 1'b1;
              wr_r <= '{addr: hli_pkg::ST_ADDR_BAUD, data: {32'h0, hli_pkg::DIV_9K6}};
              state_r <= S_DEFAULT;
            end else begin
              state_r <= S_DETECT;
            end
          end
        end
        S_DEFAULT: begin
          if (store_wr_ready) begin
            state_r <= S_DETECT;
          end
        end
        S_DETECT: begin
          unique case (mode_r)
            hli_pkg::LM_FIX_9K6: div_r <= hli_pkg::DIV_9K6;
            hli_pkg::LM_FIX_115K2: div_r <= hli_pkg::DIV_115K2;
            hli_pkg::LM_FIX_921K6: div_r <= hli_pkg::DIV_921K6;
            default: div_r <= store_info.baud_div;
          endcase
          if (!detect_mode) begin
            state_r <= S_ROUTE;
          end else if (meas_ph_r == 2'h0) begin
            if (rx_fall) begin
              meas_ph_r <= 2'h1; // Start bit seen
            end
          end else if (meas_ph_r == 2'h1) begin
            meas_r <= '0;
            if (rx_rise) begin
              meas_ph_r <= 2'h2; // Bit 0 rising edge opens the window
            end
          end else begin
            meas_r <= meas_r + MEAS_W'(1);
            if (rx_rise) begin
              div_r <= meas_bit[15:0]; // Stop bit rising edge closes it
              state_r <= S_SETTLE;
            end
          end
        end
        S_SETTLE: begin
          // UART is given its settle time before anything is sent
          settle_r <= settle_r + 32'h1;
          if (settle_done) begin
            state_r <= S_ROUTE;
          end
        end
        S_ROUTE: begin
          if (need_init) begin
            init_r <= 1'b1;
            evt_v_r <= 1'b1; // Only reached with speed fixed, taken from the store or detected
            evt_r <= '{code: hli_pkg::EVT_AWAIT_CFG, ok: 1'b1, cmd: 3'h0};
            state_r <= S_ANNOUNCE;
          end else begin
            state_r <= S_NORMAL;
          end
        end
        S_ANNOUNCE: begin
          if (evt_ready) begin
            state_r <= S_CONFIG;
          end
        end
        S_CONFIG: begin
          if (cmd_take) begin
            evt_v_r <= 1'b1;
            evt_r <= '{code: hli_pkg::EVT_CMD_ACK, ok: 1'b1, cmd: cmd.code};
            if (cmd.code == hli_pkg::CMD_BEGIN_NORMAL) begin
              evt_r.ok <= begin_ok;
              begin_r <= begin_ok;
            end
            // Settings go to any attached store, even one that booted empty
            if (store_info.present && store_cmd) begin
              wr_v_r <= 1'b1;
              unique case (cmd.code)
                hli_pkg::CMD_SET_TIMING: wr_r <= '{addr: hli_pkg::ST_ADDR_CLOCK, data: cmd.data};
                hli_pkg::CMD_STORE_LOCAL: wr_r <= '{addr: hli_pkg::ST_ADDR_LOCAL, data: cmd.data};
                default: wr_r <= '{addr: hli_pkg::ST_ADDR_PATCH + patch_idx_r, data: cmd.data};
              endcase
            end
          end
          if (begin_r && !evt_v_r) begin
            // Switch clock and speed, then open the command interface
            div_r <= pend_div_r;
            init_r <= 1'b0;
            begin_r <= 1'b0;
            state_r <= S_NORMAL;
          end
        end
        S_NORMAL: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration holding registers
  // ----------------------------------------------------------------
  // Pending values become active only on begin-normal
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr_got_r <= 1'b0;
      timing_got_r <= 1'b0;
      pend_div_r <= hli_pkg::DIV_RESET;
      pend_khz_r <= 24'h0;
      pend_addr_r <= 48'h0;
      patch_idx_r <= 8'h0;
      khz_r <= 24'h0;
      addr_r <= 48'h0;
    end else begin
      if (state_r == S_ROUTE) begin
        pend_div_r <= div_r;
        addr_r <= store_info.address;
      end
      if (cmd_take && cmd.code == hli_pkg::CMD_SET_TIMING) begin
        timing_got_r <= 1'b1;
        pend_khz_r <= cmd.data[39:16];
        pend_div_r <= cmd.data[15:0];
      end
      if (cmd_take && cmd.code == hli_pkg::CMD_STORE_LOCAL) begin
        addr_got_r <= 1'b1;
        pend_addr_r <= cmd.data;
      end
      if (cmd_take && cmd.code == hli_pkg::CMD_PATCH) begin
        patch_idx_r <= patch_idx_r + 8'h1;
      end
      if (state_r == S_CONFIG && begin_r && !evt_v_r) begin
        khz_r <= pend_khz_r;
        addr_r <= pend_addr_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_init_no_store: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == S_ROUTE && !store_info.present) |=> (state_r == S_ANNOUNCE && init_r))
    else $error("missing store did not enter initialization mode");
  a_await_event: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == S_ROUTE && need_init) |=> evt_v_r && evt_r.code == hli_pkg::EVT_AWAIT_CFG)
    else $error("awaiting-configuration event not raised");
  a_event_after_speed: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(init_r) |-> $past(state_r) == S_ROUTE && uart_ready)
    else $error("event raised before link speed known");
  a_begin_switch: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == S_CONFIG && begin_r && !evt_v_r) |=> cmd_if_on && div_r == $past(pend_div_r))
    else $error("begin-normal did not switch speed and start");
  a_begin_refused: assert property (@(posedge core_clk) disable iff (!nrst)
    (cmd_take && cmd.code == hli_pkg::CMD_BEGIN_NORMAL && !addr_got_r) |=> !begin_r && !evt_r.ok)
    else $error("begin accepted without an address");
  a_meas_divide: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == S_DETECT && meas_ph_r == 2'h2 && rx_rise) |=>
    div_r == 16'(($past(meas_r) + 1) >> 3))
    else $error("divider not measured interval over eight");
  a_settle_time: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(state_r) == S_SETTLE && state_r == S_ROUTE) |-> settle_r == 32'(SETTLE_CYC))
    else $error("uart ready without settle time");
  a_empty_default: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == S_DEFAULT) |-> wr_r.data[15:0] == hli_pkg::DIV_9K6)
    else $error("default speed is not 9600");
  a_store_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (cmd_take && store_info.present && cmd.code == hli_pkg::CMD_PATCH) |=> wr_v_r)
    else $error("patch not written to store");
  a_strap_decode: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == S_STRAP && scnt_r == 3'(hli_pkg::STRAP_SETTLE_CYC - 1) &&
    filt_r[2:0] == 3'h2) |=> detect_mode)
    else $error("strap 010 did not select detection");

  c_detect: cover property (@(posedge core_clk) disable iff (!nrst)
    state_r == S_SETTLE ##1 state_r == S_ROUTE);
  c_config_done: cover property (@(posedge core_clk) disable iff (!nrst)
    state_r == S_CONFIG ##1 state_r == S_NORMAL);
  c_direct_normal: cover property (@(posedge core_clk) disable iff (!nrst)
    state_r == S_ROUTE ##1 state_r == S_NORMAL);

endmodule

`default_nettype wire

// ---- rtl/hli_pkg.sv ----
// Constants, types and encodings shared by the host link start-up loader.
// Assumes a 100 MHz core clock and a persistent store reader on that clock.
package hli_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 100000;
  localparam int UART_SETTLE_MS = 50;   // Least settle time after detection
  localparam int UART_SETTLE_CYC = UART_SETTLE_MS * CORE_CLK_KHZ;
  localparam int STRAP_SETTLE_CYC = 4;  // Cycles before straps are latched

  // ----------------------------------------------------------------
  // Divider values, in core clock cycles per bit
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_9K6 = 16'h28b0;   // 100 MHz / 9600
  localparam logic [15:0] DIV_115K2 = 16'h0364; // 100 MHz / 115200
  localparam logic [15:0] DIV_921K6 = 16'h006c; // 100 MHz / 921600
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Persistent store word addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_ADDR_BAUD = 8'h00;
  localparam logic [7:0] ST_ADDR_CLOCK = 8'h01;
  localparam logic [7:0] ST_ADDR_LOCAL = 8'h02;
  localparam logic [7:0] ST_ADDR_PATCH = 8'h80;

  // ----------------------------------------------------------------
  // Commands and events
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_SET_TIMING = 3'h1;
  localparam logic [2:0] CMD_STORE_LOCAL = 3'h2;
  localparam logic [2:0] CMD_BEGIN_NORMAL = 3'h3;
  localparam logic [2:0] CMD_PATCH = 3'h4;
  localparam logic [1:0] EVT_AWAIT_CFG = 2'h1;
  localparam logic [1:0] EVT_CMD_ACK = 2'h2;

  typedef enum logic [2:0] {
    LM_STORE, LM_FIX_9K6, LM_FIX_115K2, LM_FIX_921K6, LM_DETECT
  } hli_link_mode_e;

  // Command from the host link parser; data layout per command:
  // set timing: [39:16] clock in kHz, [15:0] divider
  typedef struct packed {
    logic [2:0] code;
    logic [47:0] data;
  } hli_cmd_s;

  typedef struct packed {
    logic [1:0] code;
    logic ok;
    logic [2:0] cmd;
  } hli_evt_s;

  // State reported by the persistent store reader
  typedef struct packed {
    logic present;
    logic empty;
    logic complete;
    logic [15:0] baud_div;
    logic [47:0] address;
  } hli_store_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [47:0] data;
  } hli_wr_s;

endpackage

// ---- verif/hli_host_model.sv ----
// Host controller model on the far side of the host link.
// Assumes the bench calls its tasks in order and owns straps and the store.
`timescale 1ns/10ps
`default_nettype none

module hli_host_model (
  // Clock
  input wire logic core_clk,
  // Host link toward the loader
  output logic rx_pin,
  output logic cmd_valid,
  output hli_pkg::hli_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic evt_valid,
  input wire hli_pkg::hli_evt_s evt,
  output logic evt_ready
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Line idles high; clear-to-send is taken as held low throughout
  initial begin
    rx_pin = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    evt_ready = 1'b0;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // First character is a lone 0x01, sent at once; returns on stop rise
  task automatic send_sync(input int per);
    rx_pin = 1'b0;
    repeat (per) @(posedge core_clk);
    #1 rx_pin = 1'b1;
    repeat (per) @(posedge core_clk);
    #1 rx_pin = 1'b0;
    repeat (7 * per) @(posedge core_clk);
    #1 rx_pin = 1'b1;
  endtask

  // Request held until the edge that sees cmd_ready high
  task automatic send_cmd(input logic [2:0] code, input logic [47:0] data);
    int n;
    n = 0;
    @(posedge core_clk);
    #1 cmd_valid = 1'b1;
    cmd = '{code: code, data: data};
    @(posedge core_clk);
    while (cmd_ready !== 1'b1 && n < 200) begin
      n++;
      @(posedge core_clk);
    end
    #1 cmd_valid = 1'b0;
    cmd = ~cmd; // Released fields must not look valid
  endtask

  // Waits for an event, bounded, before anything else is sent
  task automatic take_evt(output hli_pkg::hli_evt_s e, output int n);
    n = 0;
    while (evt_valid !== 1'b1 && n < 2000) begin
      n++;
      @(posedge core_clk);
      #1;
    end
    e = evt;
    evt_ready = 1'b1;
    @(posedge core_clk);
    #1 evt_ready = 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- verif/tb_hli_loader.sv ----
// Self-checking bench for the start-up loader.
// Assumes the host model drives the link; the bench owns straps and store.
`timescale 1ns/10ps
`default_nettype none

module tb_hli_loader;
  localparam int SETTLE = 20;
  localparam logic [47:0] ADDR = 48'h0a1b2c3d4e5f;
  logic core_clk, nrst, clock_strap_a, clock_strap_b, clock_strap_c, rx_pin;
  logic store_wr_valid, store_wr_ready, cmd_valid, cmd_ready, evt_valid, evt_ready;
  logic uart_ready, init_mode, cmd_if_on;
  logic [15:0] uart_div;
  logic [23:0] clock_khz;
  logic [47:0] local_device_address;
  hli_pkg::hli_store_s store_info;
  hli_pkg::hli_wr_s store_wr;
  hli_pkg::hli_cmd_s cmd;
  hli_pkg::hli_evt_s evt;
  hli_pkg::hli_wr_s wrq[$];
  int miscompares = 0;
  int checks = 0;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  hli_loader #(.SETTLE_CYC(SETTLE), .MEAS_W(24)) i_hli_loader (
    .core_clk(core_clk), .nrst(nrst), .clock_strap_a(clock_strap_a),
    .clock_strap_b(clock_strap_b), .clock_strap_c(clock_strap_c), .rx_pin(rx_pin),
    .store_info(store_info), .store_wr_valid(store_wr_valid), .store_wr(store_wr),
    .store_wr_ready(store_wr_ready), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .evt_valid(evt_valid), .evt(evt), .evt_ready(evt_ready),
    .uart_div(uart_div), .clock_khz(clock_khz),
    .local_device_address(local_device_address), .uart_ready(uart_ready),
    .init_mode(init_mode), .cmd_if_on(cmd_if_on));

  hli_host_model i_hli_host_model (
    .core_clk(core_clk), .rx_pin(rx_pin), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .evt_valid(evt_valid), .evt(evt), .evt_ready(evt_ready));

  // Store writes are logged at the edge that hands them over
  always @(posedge core_clk) begin
    if (nrst === 1'b1 && store_wr_valid === 1'b1 && store_wr_ready === 1'b1) begin
      wrq.push_back(store_wr);
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Straps stay stable through reset so the latch sees settled values
  task automatic run_reset(input logic [2:0] st, input hli_pkg::hli_store_s si);
    @(posedge core_clk);
    #1 nrst = 1'b0;
    {clock_strap_a, clock_strap_b, clock_strap_c} = st;
    store_info = si;
    repeat (6) @(posedge core_clk);
    #1;
    wrq.delete();
    check(local_device_address, 48'h0);
    check(48'({cmd_if_on, init_mode, cmd_ready}), 48'h0);
    nrst = 1'b1;
  endtask

  task automatic ack(input logic [2:0] c, input logic [47:0] d, input logic ok);
    hli_pkg::hli_evt_s e;
    int n;
    i_hli_host_model.send_cmd(c, d);
    i_hli_host_model.take_evt(e, n);
    check(48'(n < 2000), 48'h1);
    check(48'({e.code, e.ok, e.cmd}), 48'({hli_pkg::EVT_CMD_ACK, ok, c}));
  endtask

  task automatic await_cfg(output int n);
    hli_pkg::hli_evt_s e;
    i_hli_host_model.take_evt(e, n);
    check(48'(n < 2000), 48'h1);
    check(48'(e.code), 48'(hli_pkg::EVT_AWAIT_CFG));
    check(48'(init_mode), 48'h1);
  endtask

  task automatic finish_cfg;
    ack(hli_pkg::CMD_STORE_LOCAL, ADDR, 1'b1);
    ack(hli_pkg::CMD_BEGIN_NORMAL, 48'h0, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check(48'(cmd_if_on), 48'h1);
    check(local_device_address, ADDR);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fixed;
    logic [2:0] st[3] = '{3'b101, 3'b110, 3'b111};
    logic [15:0] dv[3] = '{hli_pkg::DIV_9K6, hli_pkg::DIV_115K2, hli_pkg::DIV_921K6};
    int n;
    for (int i = 0; i < 3; i++) begin
      run_reset(st[i], '0);
      await_cfg(n);
      finish_cfg();
      check(48'(uart_div), 48'(dv[i]));
      check(48'(wrq.size()), 48'h0);
    end
    $display("test fixed speeds done");
  endtask

  // Measured 0x01 at 16 cycles per bit gives a divider of 0x0010
  task automatic t_detect;
    int n;
    run_reset(3'b010, '0);
    repeat (40) @(posedge core_clk);
    #1 check(48'({evt_valid, uart_ready}), 48'h0);
    i_hli_host_model.send_sync(16);
    await_cfg(n);
    check(48'(n >= SETTLE && n <= SETTLE + 40), 48'h1);
    check(48'({uart_ready, uart_div}), 48'h10010);
    ack(hli_pkg::CMD_STORE_LOCAL, ADDR, 1'b1);
    ack(hli_pkg::CMD_BEGIN_NORMAL, 48'h0, 1'b0);
    ack(hli_pkg::CMD_SET_TIMING, {8'h00, 24'd16000, 16'h0020}, 1'b1);
    finish_cfg();
    check(48'(uart_div), 48'h20);
    check(48'(clock_khz), 48'd16000);
    $display("test detection done");
  endtask

  // Empty store: defaults written first, then settings written to it during initialization
  task automatic t_empty;
    int n;
    store_wr_ready = 1'b0;
    run_reset(3'b101, '{present: 1'b1, empty: 1'b1, default: '0});
    repeat (10) @(posedge core_clk);
    #1 check(48'(store_wr_valid), 48'h1);
    check(48'({store_wr.addr, store_wr.data[15:0]}), 48'({8'h00, 16'h28b0}));
    store_wr_ready = 1'b1;
    await_cfg(n);
    ack(hli_pkg::CMD_STORE_LOCAL, ADDR, 1'b1);
    ack(hli_pkg::CMD_PATCH, 48'h00000000beef, 1'b1);
    repeat (4) @(posedge core_clk);
    #1 check(48'(wrq.size()), 48'h3);
    if (wrq.size() == 3) begin
      check(48'(wrq[1].addr), 48'(hli_pkg::ST_ADDR_LOCAL));
      check(wrq[1].data, ADDR);
      check(48'(wrq[2].addr), 48'(hli_pkg::ST_ADDR_PATCH));
      check(wrq[2].data, 48'h00000000beef);
    end
    $display("test empty store done");
  endtask

  // Complete store starts normal work; an incomplete one does not
  task automatic t_store;
    int n;
    run_reset(3'b000, '{present: 1'b1, complete: 1'b1, baud_div: 16'h1234,
                        address: ADDR, default: '0});
    repeat (SETTLE + 20) @(posedge core_clk);
    #1 check(48'({evt_valid, init_mode, cmd_if_on}), 48'h1);
    check(48'(uart_div), 48'h1234);
    check(local_device_address, ADDR);
    run_reset(3'b100, '{present: 1'b1, baud_div: 16'h1234, default: '0});
    await_cfg(n);
    $display("test stored setup done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {clock_strap_a, clock_strap_b, clock_strap_c} = 3'b000;
    store_info = '0;
    store_wr_ready = 1'b1;
    t_fixed();
    t_detect();
    t_empty();
    t_store();
    report_and_stop();
  end

  // Whole run is a few hundred cycles; this limit is far beyond it
  initial begin
    #300000;
    miscompares++;
    report_and_stop();
  end
endmodule

`default_nettype wire
